/* File: bulk_ep_regs.svh */
`ifndef BULK_EP_REGS_SVH
`define BULK_EP_REGS_SVH

// ****************************************************************
// endpoint capability constants
// ****************************************************************
`define BEP_MAX_PKT      11'h400
`define BEP_BURST_MIN    5'h01
`define BEP_BURST_MAX    5'h10
`define BEP_SEQ_INIT     5'h00
`define BEP_SEQ_LAST     5'h1F
`define BEP_XFER_W       32

`endif

/* File: bulk_ep_pkg.sv */
package bulk_ep_pkg;

    // ****************************************************************
    // state and code enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_BURST,
        ST_HALTED
    } ep_state_type;

    typedef enum logic [1:0] {
        RESP_ACK,
        RESP_NRDY,
        RESP_ERDY,
        RESP_STALL
    } resp_code_type;

    typedef enum logic [1:0] {
        DONE_COUNT,
        DONE_SHORT,
        DONE_STALL
    } done_cause_type;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic        valid;
        logic [31:0] len;
    } xfer_req_type;

    typedef struct packed {
        logic        valid;
        logic [4:0]  seq;
        logic [4:0]  npkts;
        logic [10:0] len;
    } host_pkt_type;

    typedef struct packed {
        logic        valid;
        logic [4:0]  seq;
        logic [10:0] len;
        logic        last;
    } dev_pkt_type;

    typedef struct packed {
        logic          valid;
        resp_code_type code;
        logic [4:0]    seq;
    } dev_resp_type;

    typedef struct packed {
        logic           valid;
        done_cause_type cause;
    } xfer_done_type;

endpackage

/* File: seq_counter.sv */
`timescale 1ns/100ps
`include "bulk_ep_regs.svh"

module seq_counter (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       reinit,
    input  wire logic       load,
    input  wire logic [4:0] load_val,
    input  wire logic       inc,
    output logic [4:0]      seq_q
);

    logic [4:0] seq_d;

    // reinit beats load, load beats increment; wraps 31 to 0
    always_comb begin
        seq_d = seq_q;
        if (reinit) begin
            seq_d = `BEP_SEQ_INIT;
        end else if (load) begin
            seq_d = load_val;
        end else if (inc) begin
            seq_d = (seq_q == `BEP_SEQ_LAST) ? `BEP_SEQ_INIT : seq_q + 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seq_q <= `BEP_SEQ_INIT;
        end else begin
            seq_q <= seq_d;
        end
    end

endmodule

/* File: bulk_ep_ctrl.sv */
// Behaviour
// - descriptor advertises 1024 byte packet size
// - advertised burst limited to 1 through 16
// - sequence numbers span 0 through 31
// - sent payloads full size except last
// - transfer ends: count, short packet, stall
// - transfer spans many transactions until done
// - configuration requests reset sequence and burst
// - stall or oversize OUT payload halts pipe
// - each pipe carries one direction only
`timescale 1ns/100ps
`include "bulk_ep_regs.svh"

module bulk_ep_ctrl #(
    parameter bit         IS_IN     = 1'b1,
    parameter logic [4:0] MAX_BURST = `BEP_BURST_MAX
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  cfg_reinit,
    input  wire logic                  stall_req,
    input  bulk_ep_pkg::xfer_req_type  xfer_req,
    input  bulk_ep_pkg::host_pkt_type  host_pkt,
    output bulk_ep_pkg::dev_pkt_type   dev_pkt,
    output bulk_ep_pkg::dev_resp_type  dev_resp,
    output bulk_ep_pkg::xfer_done_type xfer_done,
    output logic                       halted,
    output logic [10:0]                desc_max_pkt,
    output logic [4:0]                 desc_max_burst,
    output logic                       desc_dir_in
);

    // ****************************************************************
    // state record
    // ****************************************************************
    typedef struct packed {
        bulk_ep_pkg::ep_state_type  st;
        logic [31:0]                rem;
        logic [4:0]                 burst;
        logic                       owe_rdy;
        bulk_ep_pkg::dev_pkt_type   pkt;
        bulk_ep_pkg::dev_resp_type  resp;
        bulk_ep_pkg::xfer_done_type done;
        logic [4:0]                 desc_burst;
        logic [10:0]                desc_pkt;
        logic                       dir_in;
        logic                       halt;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;
    logic [4:0]     seq_q;
    logic           seq_reinit;
    logic           seq_load;
    logic [4:0]     seq_val;
    logic           seq_inc;
    logic [10:0]    cur_len;
    logic [31:0]    rem_after;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // keep a burst count inside 1..16
    function automatic logic [4:0] clamp_burst(input logic [4:0] n, input logic [4:0] lim);
        logic [4:0] r;
        r = n;
        if (r < `BEP_BURST_MIN) begin
            r = `BEP_BURST_MIN;
        end
        if (r > lim) begin
            r = lim;
        end
        if (r > `BEP_BURST_MAX) begin
            r = `BEP_BURST_MAX;
        end
        return r;
    endfunction

    // payload below the maximum ends the transfer
    function automatic logic is_short(input logic [10:0] len);
        return len < `BEP_MAX_PKT;
    endfunction

    // ****************************************************************
    // sequence number tracker
    // ****************************************************************
    seq_counter u_seq (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .reinit   (seq_reinit),
        .load     (seq_load),
        .load_val (seq_val),
        .inc      (seq_inc),
        .seq_q    (seq_q)
    );

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    // segment size: full packets while data remains, then the remainder
    always_comb begin
        if (s_q.rem >= {21'h000000, `BEP_MAX_PKT}) begin
            cur_len = `BEP_MAX_PKT;
        end else begin
            cur_len = s_q.rem[10:0];
        end
        if (IS_IN) begin
            rem_after = s_q.rem - {21'h000000, cur_len};
        end else if ({21'h000000, host_pkt.len} >= s_q.rem) begin
            rem_after = 32'h00000000;
        end else begin
            rem_after = s_q.rem - {21'h000000, host_pkt.len};
        end
    end

    always_comb begin
        s_d            = s_q;
        s_d.pkt.valid  = 1'b0;
        s_d.pkt.last   = 1'b0;
        s_d.resp.valid = 1'b0;
        s_d.done.valid = 1'b0;
        s_d.desc_burst = clamp_burst(MAX_BURST, `BEP_BURST_MAX);
        s_d.desc_pkt   = `BEP_MAX_PKT;
        s_d.dir_in     = IS_IN;
        seq_reinit     = 1'b0;
        seq_load       = 1'b0;
        seq_val        = host_pkt.seq;
        seq_inc        = 1'b0;
        if (cfg_reinit) begin
            // configuration request completed: back to initial pipe state
            s_d.st      = bulk_ep_pkg::ST_IDLE;
            s_d.rem     = 32'h00000000;
            s_d.burst   = 5'h00;
            s_d.owe_rdy = 1'b0;
            seq_reinit  = 1'b1;
        end else if (stall_req && s_q.st != bulk_ep_pkg::ST_HALTED) begin
            s_d.st = bulk_ep_pkg::ST_HALTED;
            if (s_q.st != bulk_ep_pkg::ST_IDLE) begin
                s_d.done.valid = 1'b1;
                s_d.done.cause = bulk_ep_pkg::DONE_STALL;
            end
        end else begin
            case (s_q.st)
                bulk_ep_pkg::ST_IDLE: begin
                    // no transfer posted: refuse and owe a ready notice
                    if (host_pkt.valid) begin
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_NRDY;
                        s_d.resp.seq   = seq_q;
                        s_d.owe_rdy    = 1'b1;
                    end
                    if (xfer_req.valid) begin
                        s_d.st  = bulk_ep_pkg::ST_ACTIVE;
                        s_d.rem = xfer_req.len;
                    end
                end
                bulk_ep_pkg::ST_ACTIVE: begin
                    if (host_pkt.valid && IS_IN) begin
                        // host grant: start a burst at the requested sequence
                        seq_load  = 1'b1;
                        s_d.burst = clamp_burst(host_pkt.npkts, s_q.desc_burst);
                        s_d.st    = bulk_ep_pkg::ST_BURST;
                    end else if (host_pkt.valid && host_pkt.len > `BEP_MAX_PKT) begin
                        // oversize payload from the host: halt the pipe
                        s_d.st         = bulk_ep_pkg::ST_HALTED;
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_STALL;
                        s_d.resp.seq   = seq_q;
                        s_d.done.valid = 1'b1;
                        s_d.done.cause = bulk_ep_pkg::DONE_STALL;
                    end else if (host_pkt.valid && host_pkt.seq == seq_q) begin
                        // in-order OUT packet accepted and acknowledged
                        seq_inc        = 1'b1;
                        s_d.rem        = rem_after;
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_ACK;
                        s_d.resp.seq   = (seq_q == `BEP_SEQ_LAST) ? `BEP_SEQ_INIT
                                                                  : seq_q + 5'h01;
                        if (is_short(host_pkt.len) || rem_after == 32'h00000000) begin
                            s_d.st         = bulk_ep_pkg::ST_IDLE;
                            s_d.done.valid = 1'b1;
                            s_d.done.cause = (rem_after == 32'h00000000)
                                           ? bulk_ep_pkg::DONE_COUNT
                                           : bulk_ep_pkg::DONE_SHORT;
                        end // otherwise the transfer waits for more transactions
                    end else if (host_pkt.valid) begin
                        // out-of-order packet: ask again from the expected number
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_ACK;
                        s_d.resp.seq   = seq_q;
                    end else if (s_q.owe_rdy) begin
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_ERDY;
                        s_d.resp.seq   = seq_q;
                        s_d.owe_rdy    = 1'b0;
                    end
                end
                bulk_ep_pkg::ST_BURST: begin
                    // one data packet a cycle until the grant or the data runs out
                    seq_inc         = 1'b1;
                    s_d.pkt.valid   = 1'b1;
                    s_d.pkt.seq     = seq_q;
                    s_d.pkt.len     = cur_len;
                    s_d.rem         = rem_after;
                    s_d.burst       = s_q.burst - 5'h01;
                    if (is_short(cur_len) || rem_after == 32'h00000000) begin
                        s_d.pkt.last   = 1'b1;
                        s_d.st         = bulk_ep_pkg::ST_IDLE;
                        s_d.done.valid = 1'b1;
                        s_d.done.cause = (rem_after == 32'h00000000)
                                       ? bulk_ep_pkg::DONE_COUNT
                                       : bulk_ep_pkg::DONE_SHORT;
                    end else if (s_q.burst == 5'h01) begin
                        s_d.pkt.last = 1'b1;
                        s_d.st       = bulk_ep_pkg::ST_ACTIVE;
                    end
                end
                bulk_ep_pkg::ST_HALTED: begin
                    // every transaction answered with stall until reinit
                    if (host_pkt.valid) begin
                        s_d.resp.valid = 1'b1;
                        s_d.resp.code  = bulk_ep_pkg::RESP_STALL;
                        s_d.resp.seq   = seq_q;
                    end
                end
                default: begin
                    s_d.st = bulk_ep_pkg::ST_IDLE;
                end
            endcase
        end
        s_d.halt = (s_d.st == bulk_ep_pkg::ST_HALTED);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q            <= '0;
            s_q.st         <= bulk_ep_pkg::ST_IDLE;
            s_q.desc_burst <= `BEP_BURST_MIN;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // descriptor fields and status straight from the state flops
    assign dev_pkt        = s_q.pkt;
    assign dev_resp       = s_q.resp;
    assign xfer_done      = s_q.done;
    assign halted         = s_q.halt;
    assign desc_max_pkt   = s_q.desc_pkt;
    assign desc_max_burst = s_q.desc_burst;
    assign desc_dir_in    = s_q.dir_in;

endmodule

/* File: bulk_ep_ctrl_sva.sv */
`timescale 1ns/100ps
module bulk_ep_ctrl_sva #(
    parameter bit         IS_IN     = 1'b1,
    parameter logic [4:0] MAX_BURST = 5'h10
) (
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    input wire logic                  cfg_reinit,
    input wire logic                  stall_req,
    input bulk_ep_pkg::xfer_req_type  xfer_req,
    input bulk_ep_pkg::host_pkt_type  host_pkt,
    input bulk_ep_pkg::dev_pkt_type   dev_pkt,
    input bulk_ep_pkg::dev_resp_type  dev_resp,
    input bulk_ep_pkg::xfer_done_type xfer_done,
    input wire logic                  halted,
    input wire logic [10:0]           desc_max_pkt,
    input wire logic [4:0]            desc_max_burst,
    input wire logic                  desc_dir_in
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    localparam logic [4:0] BURST_ADV = (MAX_BURST > 5'h10) ? 5'h10 :
                                       (MAX_BURST == 5'h00) ? 5'h01 : MAX_BURST;
    chk_desc_pkt: assert property ($past(!sys_rst) |-> desc_max_pkt == 11'h400)
        else $error("descriptor packet size wrong");
    chk_desc_burst: assert property ($past(!sys_rst) |-> desc_max_burst == BURST_ADV)
        else $error("descriptor burst size wrong");
    chk_dir_fixed: assert property ($past(!sys_rst) |-> desc_dir_in == IS_IN)
        else $error("direction flag wrong");
    chk_pkt_full: assert property (dev_pkt.valid && !dev_pkt.last |-> dev_pkt.len == 11'h400)
        else $error("non-final packet not full");
    chk_pkt_max: assert property (dev_pkt.valid |-> dev_pkt.len <= 11'h400)
        else $error("packet too long");
    chk_seq_step: assert property (dev_pkt.valid && !dev_pkt.last && !cfg_reinit && !stall_req
        |=> dev_pkt.valid && dev_pkt.seq == $past(dev_pkt.seq) + 5'h01)
        else $error("sequence did not step");
    chk_short_done: assert property (dev_pkt.valid && dev_pkt.len < 11'h400
        |-> dev_pkt.last && xfer_done.valid && xfer_done.cause != bulk_ep_pkg::DONE_STALL)
        else $error("short packet did not end transfer");
    chk_stall_halt: assert property (stall_req && !cfg_reinit |=> halted [*2])
        else $error("stall did not halt");
    chk_halt_resp: assert property (halted && host_pkt.valid && !cfg_reinit
        |=> dev_resp.valid && dev_resp.code == bulk_ep_pkg::RESP_STALL)
        else $error("halted pipe not answering stall");
    chk_reinit_clr: assert property (cfg_reinit |=> !halted)
        else $error("reinit did not clear halt");
    cov_short: cover property (dev_pkt.valid && dev_pkt.len < 11'h400);
    cov_stall: cover property (xfer_done.valid && xfer_done.cause == bulk_ep_pkg::DONE_STALL);
    cov_wrap: cover property (dev_pkt.valid && dev_pkt.seq == 5'h1F ##1 dev_pkt.valid);
endmodule

bind bulk_ep_ctrl bulk_ep_ctrl_sva #(.IS_IN(IS_IN), .MAX_BURST(MAX_BURST)) sva_inst (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .cfg_reinit     (cfg_reinit),
    .stall_req      (stall_req),
    .xfer_req       (xfer_req),
    .host_pkt       (host_pkt),
    .dev_pkt        (dev_pkt),
    .dev_resp       (dev_resp),
    .xfer_done      (xfer_done),
    .halted         (halted),
    .desc_max_pkt   (desc_max_pkt),
    .desc_max_burst (desc_max_burst),
    .desc_dir_in    (desc_dir_in)
);

/* File: host_model.sv */
`timescale 1ns/100ps
module host_model (
    input wire logic                  core_clk,
    input bulk_ep_pkg::dev_resp_type  dev_resp,
    output bulk_ep_pkg::host_pkt_type host_pkt
);
    logic paused = 1'b0;
    initial host_pkt = '0;
    // not-ready parks the endpoint, ready notice resumes it
    always @(posedge core_clk) begin
        if (dev_resp.valid === 1'b1 && dev_resp.code === bulk_ep_pkg::RESP_NRDY) paused <= 1'b1;
        if (dev_resp.valid === 1'b1 && dev_resp.code === bulk_ep_pkg::RESP_ERDY) paused <= 1'b0;
    end
    // one grant at a time to the only pipe, payload field left at zero
    // no control traffic or other pipe competes here
    task automatic send(input logic [4:0] seq, input logic [4:0] n);
        for (int i = 0; i < 50 && paused; i++) @(negedge core_clk);
        @(negedge core_clk);
        host_pkt <= '{1'b1, seq, n, 11'h000};
        @(negedge core_clk);
        host_pkt <= '{1'b0, ~seq, ~n, 11'h7FF}; // released fields scrambled
    endtask
endmodule

/* File: bulk_endpoint_transfer_ctrl_test.sv */
`timescale 1ns/100ps
module bulk_endpoint_transfer_ctrl_test;
    logic                       core_clk   = 1'b0;
    logic                       sys_rst    = 1'b1;
    logic                       cfg_reinit = 1'b0;
    logic                       stall_req  = 1'b0;
    bulk_ep_pkg::xfer_req_type  xfer_req   = '0;
    bulk_ep_pkg::host_pkt_type  host_pkt;
    bulk_ep_pkg::dev_pkt_type   dev_pkt;
    bulk_ep_pkg::dev_resp_type  dev_resp;
    bulk_ep_pkg::xfer_done_type xfer_done;
    logic                       halted;
    logic [10:0]                desc_max_pkt;
    logic [4:0]                 desc_max_burst;
    logic                       desc_dir_in;
    int                         err_total = 0;
    int                         compares  = 0;
    logic [31:0]                rem;
    logic [4:0]                 s;
    bulk_ep_pkg::xfer_req_type  o_req      = '0;
    bulk_ep_pkg::host_pkt_type  o_pkt      = '0;
    bulk_ep_pkg::dev_resp_type  o_resp;
    bulk_ep_pkg::xfer_done_type o_done;
    bulk_ep_pkg::dev_resp_type  exp_oresp[$];
    bulk_ep_pkg::xfer_done_type exp_odone[$];
    bulk_ep_pkg::dev_pkt_type   exp_pkt[$];
    bulk_ep_pkg::resp_code_type exp_resp[$];
    bulk_ep_pkg::xfer_done_type exp_done[$];
    logic [47:0]                cases[4] = '{{32'd1500, 8'd5, 8'd4}, {32'd4096, 8'd31, 8'd2},
                                             {32'd1024, 8'd0, 8'd0}, {32'd3000, 8'd2, 8'd31}};
    always #20 core_clk = ~core_clk;
    bulk_ep_ctrl bulk_ep_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .cfg_reinit(cfg_reinit), .stall_req(stall_req), .xfer_req(xfer_req),
        .host_pkt(host_pkt), .dev_pkt(dev_pkt), .dev_resp(dev_resp), .xfer_done(xfer_done),
        .halted(halted), .desc_max_pkt(desc_max_pkt), .desc_max_burst(desc_max_burst),
        .desc_dir_in(desc_dir_in));
    host_model host_model_inst (.core_clk(core_clk), .dev_resp(dev_resp), .host_pkt(host_pkt));
    // second pipe in the OUT direction, driven straight from the bench
    bulk_ep_ctrl #(.IS_IN(1'b0)) bulk_ep_ctrl_out_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .cfg_reinit(cfg_reinit), .stall_req(stall_req), .xfer_req(o_req), .host_pkt(o_pkt),
        .dev_pkt(), .dev_resp(o_resp), .xfer_done(o_done), .halted(), .desc_max_pkt(),
        .desc_max_burst(), .desc_dir_in());
    // ****************************************************************
    // compare tasks
    // ****************************************************************
    task automatic report(input logic bad, input string msg);
        compares++;
        if (bad) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic cmp_lvl(input logic ok, input string msg);
        report(ok !== 1'b1, msg);
    endtask
    task automatic cmp_pkt();
        report(exp_pkt.size() == 0 || dev_pkt !== exp_pkt.pop_front(), "data packet differs");
    endtask
    task automatic cmp_resp();
        report(exp_resp.size() == 0 || dev_resp.code !== exp_resp.pop_front(), "response differs");
    endtask
    task automatic cmp_done();
        report(exp_done.size() == 0 || xfer_done !== exp_done.pop_front(), "completion differs");
    endtask
    task automatic cmp_oresp();
        report(exp_oresp.size() == 0 || o_resp !== exp_oresp.pop_front(), "out response differs");
    endtask
    task automatic cmp_odone();
        report(exp_odone.size() == 0 || o_done !== exp_odone.pop_front(), "out completion differs");
    endtask
    // watch the outputs once each rising edge has settled
    always @(posedge core_clk) begin
        #1;
        if (dev_pkt.valid === 1'b1) cmp_pkt();
        if (dev_resp.valid === 1'b1) cmp_resp();
        if (xfer_done.valid === 1'b1) cmp_done();
        if (o_resp.valid === 1'b1) cmp_oresp();
        if (o_done.valid === 1'b1) cmp_odone();
    end
    // ****************************************************************
    // stimulus
    // ****************************************************************
    task automatic pulse(ref logic sig);
        @(negedge core_clk) sig = 1'b1;
        @(negedge core_clk) sig = 1'b0;
    endtask
    task automatic post(input logic [31:0] len);
        @(negedge core_clk) xfer_req = '{1'b1, len};
        rem = len;
        @(negedge core_clk) xfer_req = '{1'b0, ~len};
    endtask
    // one OUT data packet and the acknowledgement it should earn
    task automatic opkt(input logic [4:0] sq, input logic [10:0] len, input logic [4:0] nxt);
        exp_oresp.push_back('{1'b1, bulk_ep_pkg::RESP_ACK, nxt});
        @(negedge core_clk) o_pkt = '{1'b1, sq, 5'h01, len};
        @(negedge core_clk) o_pkt = '{1'b0, ~sq, 5'h00, ~len};
    endtask
    // expected packets of one grant, then the grant itself
    task automatic grant(input logic [4:0] sq, input logic [4:0] cnt);
        logic [4:0] k;
        logic [10:0] l;
        k = (cnt == 5'h00) ? 5'h01 : (cnt > 5'h10) ? 5'h10 : cnt;
        for (int i = 0; i < k && rem != 0; i++) begin
            l = (rem > 32'h400) ? 11'h400 : rem[10:0];
            rem = rem - l;
            exp_pkt.push_back('{1'b1, sq + i[4:0], l, (i == k - 1) || (rem == 0)});
            if (rem == 0) exp_done.push_back('{1'b1, bulk_ep_pkg::DONE_COUNT});
        end
        host_model_inst.send(sq, k);
        repeat (20) @(negedge core_clk);
        s = sq + k;
    endtask
    task automatic run(input logic [31:0] len, input logic [4:0] sq, input logic [4:0] cnt);
        post(len);
        s = sq;
        while (rem != 0) grant(s, cnt);
    endtask
    task automatic finish_test();
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h2a652933));
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        cmp_lvl(desc_max_pkt === 11'h400, "packet size field");
        cmp_lvl(desc_max_burst === 5'h10, "burst size field");
        cmp_lvl(desc_dir_in === 1'b1, "direction field");
        // out pipe: two full packets end on count, then a short one ends early
        @(negedge core_clk) o_req = '{1'b1, 32'd2048};
        @(negedge core_clk) o_req = '0;
        opkt(5'h00, 11'h400, 5'h01);
        exp_odone.push_back('{1'b1, bulk_ep_pkg::DONE_COUNT});
        opkt(5'h01, 11'h400, 5'h02);
        @(negedge core_clk) o_req = '{1'b1, 32'd3000};
        @(negedge core_clk) o_req = '0;
        opkt(5'h02, 11'h400, 5'h03);
        opkt(5'h07, 11'h400, 5'h03); // out of order: expected number asked again
        exp_odone.push_back('{1'b1, bulk_ep_pkg::DONE_SHORT});
        opkt(5'h03, 11'(1 + $urandom_range(1022)), 5'h04);
        exp_resp.push_back(bulk_ep_pkg::RESP_NRDY);
        exp_resp.push_back(bulk_ep_pkg::RESP_ERDY);
        host_model_inst.send(5'h00, 5'h01); // idle grant is refused, ready owed
        run(32'd700, 5'h00, 5'h01);
        foreach (cases[i]) run(cases[i][47:16], cases[i][12:8], cases[i][4:0]);
        repeat (4) run($urandom_range(20000, 1), 5'($urandom()), 5'($urandom()));
        post(32'd5000);
        grant(5'h00, 5'h01);
        exp_done.push_back('{1'b1, bulk_ep_pkg::DONE_STALL});
        pulse(stall_req);
        cmp_lvl(halted === 1'b1, "halt after stall");
        exp_resp.push_back(bulk_ep_pkg::RESP_STALL);
        host_model_inst.send(5'h01, 5'h01);
        repeat (3) @(negedge core_clk);
        pulse(cfg_reinit);
        cmp_lvl(halted === 1'b0, "halt cleared");
        run(32'd1500, 5'h00, 5'h10);
        cmp_lvl(exp_pkt.size() + exp_resp.size() + exp_done.size() == 0, "results missing");
        cmp_lvl(exp_oresp.size() + exp_odone.size() == 0, "out results missing");
        finish_test();
    end
endmodule
